//--- mfr_phy_model.sv
// behavioural mii transmitter that answers each transmit attempt
`timescale 1ns/100ps
module mfr_phy_model (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [1:0] i_mode, // 0 clean, 1 collision, 2 late collision
    output logic            o_done,
    output logic            o_coll,
    output logic            o_late
);
    logic [2:0] cnt_r = 3'h0; // cycles left in the attempt
    initial {o_done, o_coll, o_late} = 3'h0;
    // answer four cycles after go; results are one-cycle pulses, as the mac expects
    always @(posedge i_clk) begin
        cnt_r  <= i_go ? 3'h4 : ((cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0);
        o_done <= (cnt_r == 3'h1) && (i_mode == 2'h0);
        o_coll <= (cnt_r == 3'h1) && (i_mode != 2'h0);
        o_late <= (cnt_r == 3'h1) && (i_mode == 2'h2);
    end
endmodule // mfr_phy_model

//--- mfr_pkg.sv
// constants, types and register map of the mac filter and retry controller
// Summary of operation
// - select 0: accept only station address matches and broadcasts
// - select 1: multicast checked against hash table
// - hash mode: unicast hashed if hash-only, else perfect
// - late collision retried if enabled, else abandoned
// - late collision always flagged in transmit status
// - broadcast reject drops broadcasts, else forwards all
// - broadcast wakeup frame wakes despite broadcast reject
// - retry disable: one attempt, drop, retry error
// - otherwise up to 16 attempts, then retry error
// - pad strip removes pad and fcs below 46
// - length 46 or more, or strip off: unmodified
// - back-off r below 2^K, K=min(retries,10)
// - back-off count taken from low lfsr bits
// - two-bit back-off limit field, bits 7:6, reset 00
// - limit caps lfsr bits at 10, 8, 4, 1
// - hash-only bit hashes unicast too, only in hash mode
package mfr_pkg;
    // register byte offsets
    localparam logic [11:0] MAC_CONTROL_OFS = 12'h100;
    localparam logic [11:0] ADDR_HIGH_OFS   = 12'h104;
    localparam logic [11:0] ADDR_LOW_OFS    = 12'h108;
    localparam logic [11:0] HASH_HIGH_OFS   = 12'h10c;
    localparam logic [11:0] HASH_LOW_OFS    = 12'h110;
    localparam logic [11:0] WAKEUP_CSR_OFS  = 12'h12c;
    localparam logic [11:0] TX_STATUS_OFS   = 12'h140;
    // mac_control field positions and reset value
    localparam int HASH_ONLY_BIT    = 15;
    localparam int HASH_PERFECT_BIT = 13;
    localparam int LATE_RETRY_BIT   = 12;
    localparam int BROADCAST_REJECT_REJECT_BIT = 11;
    localparam int RETRY_DIS_BIT    = 10;
    localparam int PAD_STRIP_BIT    = 8;
    localparam int BO_LIMIT_LSB     = 6;
    localparam logic [31:0] MAC_CONTROL_RST   = 32'h0000_0000;
    localparam logic [31:0] MAC_CONTROL_WMASK = 32'h0000_bdc0;
    localparam int WAKEUP_EN_BIT    = 2;
    // frame and retry figures
    localparam logic [15:0] MIN_PAYLOAD   = 16'h002e; // 46 bytes
    localparam logic [10:0] HEADER_BYTES  = 11'h00e;  // da, sa, length
    localparam logic [4:0]  MAX_ATTEMPTS  = 5'h10;    // 16
    localparam int          BACKOFF_CAP   = 10;
    localparam logic [1:0]  BO_LIMIT_RST  = 2'h0;
    localparam logic [9:0]  LFSR_SEED     = 10'h001;
    // slot time in bit times and the clock it is counted in
    localparam int SLOT_BIT_TIMES = 512;
    localparam int BIT_NS_100M    = 10;
    localparam int BIT_NS_10M     = 100;
    localparam int CLK_NS         = 20;
    localparam logic [11:0] SLOT_CYC_100M = 12'(SLOT_BIT_TIMES * BIT_NS_100M / CLK_NS);
    localparam logic [11:0] SLOT_CYC_10M  = 12'(SLOT_BIT_TIMES * BIT_NS_10M / CLK_NS);

    // header summary handed over by the receive parser at frame start
    typedef struct packed {
        logic [47:0] dest;      // first byte in [47:40], group bit is [40]
        logic [15:0] len_field;
        logic [5:0]  hash_idx;  // from the receive crc unit
        logic        wakeup;    // frame matched a wakeup pattern
    } mfr_rx_hdr_t;
    // word held in the receive fifo
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } mfr_rx_word_t;
    // per-packet transmit status
    typedef struct packed {
        logic       late_coll;
        logic       retry_err;
        logic       abandoned;
        logic [4:0] attempts;
    } mfr_tx_status_t;
    // transmit retry states
    typedef enum logic [1:0] {
        TX_IDLE    = 2'b00,
        TX_XMIT    = 2'b01,
        TX_BACKOFF = 2'b10,
        TX_REPORT  = 2'b11
    } mfr_tx_state_t;
endpackage

//--- mfr_top.sv
// receive address filter with pad stripping, receive fifo, and transmit retry control
`timescale 1ns/100ps

// receive buffer: flags kept in flip-flops so in ready and out valid come from registers
module mfr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock, enable, reset
    input  wire logic             i_clk,
    input  wire logic             i_ce,
    input  wire logic             i_rst_b,
    // filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // draining side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];    // storage
    logic [AW-1:0]    wr_ptr_r;       // next slot to write
    logic [AW-1:0]    rd_ptr_r;       // next slot to read
    logic [AW:0]      count_r;        // words held
    logic [AW:0]      count_nxt;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    assign count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
    assign o_out_data = mem[rd_ptr_r];

    // pointers and registered flags
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            o_in_ready  <= 1'b1;
            o_out_valid <= 1'b0;
        end else if (i_ce) begin
            wr_ptr_r    <= wr_ptr_r + AW'(push);
            rd_ptr_r    <= rd_ptr_r + AW'(pop);
            count_r     <= count_nxt;
            o_in_ready  <= count_nxt != (AW+1)'(DEPTH);
            o_out_valid <= count_nxt != '0;
        end
    end

    // storage has no reset, it is qualified by the flags
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end
endmodule // mfr_fifo

module mfr_top
    import mfr_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // clock, enable, reset
    input  wire logic           i_core_clk,
    input  wire logic           i_ce,
    input  wire logic           i_rst_b,
    // register port
    input  wire logic [11:0]    i_reg_addr,
    input  wire logic [31:0]    i_reg_wdata,
    input  wire logic           i_reg_wr,
    input  wire logic           i_reg_rd,
    output logic [31:0]         o_reg_rdata,
    // receive header and byte stream from the parser
    input  wire logic           i_rx_hdr_valid,
    input  wire mfr_rx_hdr_t    i_rx_hdr,
    input  wire logic           i_rx_valid,
    input  wire logic [7:0]     i_rx_data,
    input  wire logic           i_rx_last,
    output logic                o_rx_in_ready,
    // filtered receive stream to the application
    output logic                o_rx_valid,
    output mfr_rx_word_t        o_rx_word,
    input  wire logic           i_rx_ready,
    output logic                o_rx_accept,
    output logic                o_wake,
    // transmit side, to and from the mii transmitter
    input  wire logic           i_speed_100,
    input  wire logic           i_tx_start,
    input  wire logic           i_tx_done,
    input  wire logic           i_tx_coll,
    input  wire logic           i_tx_late,
    output logic                o_tx_go,
    output logic                o_tx_busy,
    output logic                o_tx_status_valid,
    output mfr_tx_status_t      o_tx_status
);
    // reset release through two flops
    logic rst_meta_r;
    logic rst_b_r;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_b_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_b_r    <= rst_meta_r;
        end
    end

    // lfsr bits allowed by the limit field, further capped by K
    function automatic logic [9:0] bo_mask(input logic [4:0] n, input logic [1:0] lim);
        logic [4:0] k;
        logic [4:0] cap;
        k   = (n > 5'(BACKOFF_CAP)) ? 5'(BACKOFF_CAP) : n;
        cap = (lim == 2'h0) ? 5'h0a : (lim == 2'h1) ? 5'h08 :
              (lim == 2'h2) ? 5'h04 : 5'h01;
        if (cap < k) begin
            k = cap;
        end
        bo_mask = 10'((11'h001 << k) - 11'h001);
    endfunction

    // ---------------- registers ----------------
    logic [31:0]    mac_control_r;   // mode bits steering filter and retry
    logic [47:0]    station_addr_r;  // perfect filter address
    logic [63:0]    hash_table_r;    // multicast hash bits
    logic           wakeup_en_r;     // wakeup frame detection on
    mfr_tx_status_t tx_status_r;     // last per-packet status, readable

    wire hash_only    = mac_control_r[HASH_ONLY_BIT];
    wire hash_select  = mac_control_r[HASH_PERFECT_BIT];
    wire late_retry   = mac_control_r[LATE_RETRY_BIT];
    wire broadcast_reject_reject = mac_control_r[BROADCAST_REJECT_REJECT_BIT];
    wire retry_dis    = mac_control_r[RETRY_DIS_BIT];
    wire pad_strip    = mac_control_r[PAD_STRIP_BIT];
    wire [1:0] bo_limit = mac_control_r[BO_LIMIT_LSB+1:BO_LIMIT_LSB];

    // address decode
    wire sel_ctl  = i_reg_addr == MAC_CONTROL_OFS;
    wire sel_ah   = i_reg_addr == ADDR_HIGH_OFS;
    wire sel_al   = i_reg_addr == ADDR_LOW_OFS;
    wire sel_hh   = i_reg_addr == HASH_HIGH_OFS;
    wire sel_hl   = i_reg_addr == HASH_LOW_OFS;
    wire sel_wk   = i_reg_addr == WAKEUP_CSR_OFS;
    wire sel_st   = i_reg_addr == TX_STATUS_OFS;
    // read mux; unmapped addresses read zero
    wire [31:0] rd_mux = sel_ctl ? mac_control_r :
                         sel_ah  ? {16'h0000, station_addr_r[47:32]} :
                         sel_al  ? station_addr_r[31:0] :
                         sel_hh  ? hash_table_r[63:32] :
                         sel_hl  ? hash_table_r[31:0] :
                         sel_wk  ? {29'h0, wakeup_en_r, 2'h0} :
                         sel_st  ? {24'h0, tx_status_r} : 32'h0000_0000;

    // register writes and one-cycle read answer
    always_ff @(posedge i_core_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            mac_control_r  <= MAC_CONTROL_RST;
            station_addr_r <= '0;
            hash_table_r   <= '0;
            wakeup_en_r    <= 1'b0;
            o_reg_rdata    <= '0;
        end else if (i_ce) begin
            if (i_reg_wr && sel_ctl) begin
                mac_control_r <= i_reg_wdata & MAC_CONTROL_WMASK; // reserved bits stay zero
            end
            if (i_reg_wr && sel_ah) begin
                station_addr_r[47:32] <= i_reg_wdata[15:0];
            end
            if (i_reg_wr && sel_al) begin
                station_addr_r[31:0] <= i_reg_wdata;
            end
            if (i_reg_wr && sel_hh) begin
                hash_table_r[63:32] <= i_reg_wdata;
            end
            if (i_reg_wr && sel_hl) begin
                hash_table_r[31:0] <= i_reg_wdata;
            end
            if (i_reg_wr && sel_wk) begin
                wakeup_en_r <= i_reg_wdata[WAKEUP_EN_BIT];
            end
            o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------- receive filter ----------------
    wire is_broadcast_reject   = &i_rx_hdr.dest;
    wire is_mcast   = i_rx_hdr.dest[40];
    wire perfect_ok = i_rx_hdr.dest == station_addr_r;
    wire hash_ok    = hash_table_r[i_rx_hdr.hash_idx];
    // multicast: hash in hash mode, otherwise perfect
    wire mcast_ok   = hash_select ? hash_ok : perfect_ok;
    // unicast: hash only when both hash mode and hash-only are set
    wire ucast_ok   = (hash_select && hash_only) ? hash_ok : perfect_ok;
    wire accept_now = is_broadcast_reject ? !broadcast_reject_reject :
                      is_mcast ? mcast_ok : ucast_ok;
    // broadcast wakeup bypasses the reject bit
    wire wake_now   = wakeup_en_r && i_rx_hdr.wakeup && is_broadcast_reject;
    // short frames lose pad and fcs when stripping is on
    wire strip_now  = pad_strip && (i_rx_hdr.len_field < MIN_PAYLOAD);

    logic        strip_r;       // current frame is being cut short
    logic [10:0] keep_len_r;    // bytes kept when cutting
    logic [10:0] byte_idx_r;    // byte position within the frame
    wire         fifo_ready;
    wire         byte_take = i_rx_valid && fifo_ready;
    wire         byte_keep = !strip_r || (byte_idx_r < keep_len_r);
    wire         cut_last  = strip_r && (byte_idx_r == keep_len_r - 11'h001);
    wire         push      = byte_take && o_rx_accept && byte_keep;
    mfr_rx_word_t push_word;
    assign push_word.data = i_rx_data;
    assign push_word.last = i_rx_last || cut_last;
    assign o_rx_in_ready  = fifo_ready;

    // frame decision latched at header, byte counting after it
    always_ff @(posedge i_core_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            o_rx_accept <= 1'b0;
            o_wake      <= 1'b0;
            strip_r     <= 1'b0;
            keep_len_r  <= '0;
            byte_idx_r  <= '0;
        end else if (i_ce) begin
            o_wake <= i_rx_hdr_valid && wake_now;
            if (i_rx_hdr_valid) begin
                o_rx_accept <= accept_now;
                strip_r     <= strip_now;
                keep_len_r  <= HEADER_BYTES + i_rx_hdr.len_field[10:0];
                byte_idx_r  <= '0;
            end else if (byte_take) begin
                byte_idx_r <= i_rx_last ? 11'h000 : byte_idx_r + 11'h001;
            end
        end
    end

    wire          fifo_out_valid;
    mfr_rx_word_t fifo_out_word;
    wire          out_load = fifo_out_valid && (!o_rx_valid || i_rx_ready);
    mfr_fifo #(.WIDTH($bits(mfr_rx_word_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_clk       (i_core_clk),
        .i_ce        (i_ce),
        .i_rst_b     (rst_b_r),
        .i_in_valid  (push),
        .i_in_data   (push_word),
        .o_in_ready  (fifo_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_word),
        .i_out_ready (out_load)
    );

    // output register stage so the stream leaves from flops
    always_ff @(posedge i_core_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            o_rx_valid <= 1'b0;
            o_rx_word  <= '0;
        end else if (i_ce) begin
            if (out_load) begin
                o_rx_valid <= 1'b1;
                o_rx_word  <= fifo_out_word;
            end else if (i_rx_ready) begin
                o_rx_valid <= 1'b0;
            end
        end
    end

    // ---------------- transmit retry ----------------
    mfr_tx_state_t tx_state_r, tx_state_nxt;
    logic [4:0]    attempts_r, attempts_nxt;   // attempts made on this frame
    logic          late_r, late_nxt;           // late collision seen on this frame
    logic [9:0]    slots_r, slots_nxt;         // slot times still to wait
    logic [11:0]   cyc_r, cyc_nxt;             // cycles left in current slot
    logic [9:0]    lfsr_r;                     // free-running random source
    logic          go_nxt;
    logic          rep_nxt;
    logic          err_nxt;
    logic          abn_nxt;
    wire  [11:0]   slot_cyc = i_speed_100 ? SLOT_CYC_100M : SLOT_CYC_10M;
    wire  [9:0]    draw     = lfsr_r & bo_mask(attempts_r, bo_limit);

    // next-state decisions for one frame
    always_comb begin
        tx_state_nxt = tx_state_r;
        attempts_nxt = attempts_r;
        late_nxt     = late_r;
        slots_nxt    = slots_r;
        cyc_nxt      = cyc_r;
        go_nxt       = 1'b0;
        rep_nxt      = 1'b0;
        err_nxt      = tx_status_r.retry_err;
        abn_nxt      = tx_status_r.abandoned;
        case (tx_state_r)
            TX_IDLE: begin
                if (i_tx_start) begin
                    tx_state_nxt = TX_XMIT;
                    attempts_nxt = 5'h01;
                    late_nxt     = 1'b0;
                    go_nxt       = 1'b1;
                end
            end
            TX_XMIT: begin
                if (i_tx_coll) begin
                    late_nxt = late_r || i_tx_late;
                    if (i_tx_late && !late_retry) begin
                        tx_state_nxt = TX_REPORT;
                        err_nxt      = 1'b0;
                        abn_nxt      = 1'b1;
                    end else if (retry_dis || attempts_r == MAX_ATTEMPTS) begin
                        tx_state_nxt = TX_REPORT;
                        err_nxt      = 1'b1;
                        abn_nxt      = 1'b1;
                    end else begin
                        tx_state_nxt = TX_BACKOFF;
                        slots_nxt    = draw;
                        cyc_nxt      = '0;
                    end
                end else if (i_tx_done) begin
                    tx_state_nxt = TX_REPORT;
                    err_nxt      = 1'b0;
                    abn_nxt      = 1'b0;
                end
            end
            TX_BACKOFF: begin
                if (cyc_r != 12'h000) begin
                    cyc_nxt = cyc_r - 12'h001;
                end else if (slots_r == 10'h000) begin
                    tx_state_nxt = TX_XMIT;
                    attempts_nxt = attempts_r + 5'h01;
                    go_nxt       = 1'b1;
                end else begin
                    slots_nxt = slots_r - 10'h001;
                    cyc_nxt   = slot_cyc - 12'h001;
                end
            end
            TX_REPORT: begin
                tx_state_nxt = TX_IDLE;
                rep_nxt      = 1'b1;
            end
            default: begin
                tx_state_nxt = TX_IDLE;
            end
        endcase
    end

    // transmit state registers; status lives in tx_status_r
    always_ff @(posedge i_core_clk or negedge rst_b_r) begin
        if (!rst_b_r) begin
            tx_state_r        <= TX_IDLE;
            attempts_r        <= '0;
            late_r            <= 1'b0;
            slots_r           <= '0;
            cyc_r             <= '0;
            lfsr_r            <= LFSR_SEED;
            tx_status_r       <= '0;
            o_tx_go           <= 1'b0;
            o_tx_busy         <= 1'b0;
            o_tx_status_valid <= 1'b0;
            o_tx_status       <= '0;
        end else if (i_ce) begin
            tx_state_r        <= tx_state_nxt;
            attempts_r        <= attempts_nxt;
            late_r            <= late_nxt;
            slots_r           <= slots_nxt;
            cyc_r             <= cyc_nxt;
            lfsr_r            <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
            tx_status_r       <= '{late_nxt, err_nxt, abn_nxt, attempts_nxt};
            o_tx_go           <= go_nxt;
            o_tx_busy         <= tx_state_nxt != TX_IDLE;
            o_tx_status_valid <= rep_nxt;
            if (rep_nxt) begin
                o_tx_status <= tx_status_r;
            end
        end
    end

    // ---------------- checks ----------------
    a_broadcast_reject_reject_drop: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && i_rx_hdr_valid && is_broadcast_reject |=> o_rx_accept == !$past(broadcast_reject_reject))
        else $error("broadcast accept does not follow reject bit");
    a_perfect_unicast: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && i_rx_hdr_valid && !hash_select && !is_broadcast_reject |=> o_rx_accept == $past(perfect_ok))
        else $error("perfect filter decision wrong");
    a_hash_only_ucast: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && i_rx_hdr_valid && hash_select && hash_only && !is_mcast |=> o_rx_accept == $past(hash_ok))
        else $error("hash-only unicast not hashed");
    a_hash_mcast_path: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && i_rx_hdr_valid && hash_select && is_mcast && !is_broadcast_reject |=> o_rx_accept == $past(hash_ok))
        else $error("multicast not hash filtered");
    a_broadcast_reject_wakeup: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && i_rx_hdr_valid && wakeup_en_r && i_rx_hdr.wakeup && is_broadcast_reject |=> o_wake)
        else $error("broadcast wakeup missed");
    a_strip_keeps_len: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        push && strip_r |-> byte_idx_r < keep_len_r)
        else $error("pad or fcs byte written while stripping");
    a_late_abandon: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && tx_state_r == TX_XMIT && i_tx_coll && i_tx_late && !late_retry
        |=> tx_state_r == TX_REPORT
        ##1 (!$past(i_ce) || (o_tx_status_valid && o_tx_status.abandoned && o_tx_status.late_coll)))
        else $error("late collision not abandoned");
    a_single_attempt: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && tx_state_r == TX_XMIT && i_tx_coll && retry_dis && !i_tx_late
        |=> tx_state_r == TX_REPORT ##1 (!$past(i_ce) || (o_tx_status_valid && o_tx_status.retry_err)))
        else $error("retry disable did not stop after one attempt");
    a_attempt_cap: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        attempts_r <= MAX_ATTEMPTS)
        else $error("more than sixteen attempts");
    a_backoff_bound: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
        i_ce && tx_state_r == TX_XMIT && tx_state_nxt == TX_BACKOFF
        |=> (slots_r & ~bo_mask($past(attempts_r), bo_limit)) == 10'h000)
        else $error("back-off draw above limit");
endmodule // mfr_top

//--- tb_top.sv
// register-level testbench for the mac filter and retry controller
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
    import mfr_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, hv = 1'b0, bv = 1'b0, st = 1'b0, ce = 1'b1, woke = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0]  mode = 2'h0;  // phy answer for the next attempt
    mfr_rx_hdr_t hdr = '0;
    mfr_rx_word_t word;
    mfr_tx_status_t sts;
    logic acc, rxv, go, busy, sv, done, coll, late, wake, inrdy;
    int checks_done = 0, fail_count = 0;
    mfr_top mfr_top_inst (.i_core_clk(clk), .i_ce(ce), .i_rst_b(rst_b), .i_reg_addr(addr),
        .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_rx_hdr_valid(hv),
        .i_rx_hdr(hdr), .i_rx_valid(bv), .i_rx_data(8'h5a), .i_rx_last(1'b1), .o_rx_in_ready(inrdy),
        .o_rx_valid(rxv), .o_rx_word(word), .i_rx_ready(1'b1), .o_rx_accept(acc), .o_wake(wake),
        .i_speed_100(1'b1), .i_tx_start(st), .i_tx_done(done), .i_tx_coll(coll), .i_tx_late(late),
        .o_tx_go(go), .o_tx_busy(busy), .o_tx_status_valid(sv), .o_tx_status(sts));
    mfr_phy_model mfr_phy_model_inst (.i_clk(clk), .i_go(go), .i_mode(mode), .o_done(done),
        .o_coll(coll), .o_late(late));
    initial forever #10 clk = ~clk;
    // latch the one-cycle wake pulse so it cannot slip between samples
    always @(posedge clk) if (wake) woke <= 1'b1;
    task automatic finish_test;
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0; #1;
        `CHK("rdata", e, rdat)
    endtask
    // one frame start, then wait a bounded time for the status pulse
    task automatic xmit(input logic [1:0] m, input logic [7:0] e);
        mode <= m;
        @(posedge clk); st <= 1'b1;
        @(posedge clk); st <= 1'b0;
        // sixteen attempts with one-slot back-off fit well inside this bound
        for (int i = 0; i < 6000 && !sv; i++) begin @(posedge clk); #1; end
        `CHK("tx_status_valid", 1'b1, sv)
        `CHK("tx_status", e, sts)
        `CHK("tx_busy", 1'b0, busy)
    endtask
    task automatic header(input logic [47:0] d, input logic w);
        @(posedge clk); hdr <= '{d, 16'h0040, 6'h00, w}; hv <= 1'b1;
        @(posedge clk); hv <= 1'b0;
        @(posedge clk); #1;
    endtask
    initial begin #1ms; fail_count++; finish_test; end // hang guard, 50000 cycles
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(MAC_CONTROL_OFS, MAC_CONTROL_RST);
        wreg(MAC_CONTROL_OFS, 32'hffff_ffff);
        rreg(MAC_CONTROL_OFS, MAC_CONTROL_WMASK);
        rreg(12'h200, 32'h0);
        xmit(2'h1, 8'h61);
        wreg(WAKEUP_CSR_OFS, 32'h4);
        header(48'hffff_ffff_ffff, 1'b1);
        `CHK("broadcast_reject accept", 1'b0, acc)
        `CHK("wake", 1'b1, woke)
        wreg(MAC_CONTROL_OFS, 32'h0);
        xmit(2'h2, 8'ha1);
        // clock enable low: a write in that window must not land
        @(posedge clk) ce <= 1'b0;
        wreg(MAC_CONTROL_OFS, 32'h0000_0100);
        @(posedge clk) ce <= 1'b1;
        rreg(MAC_CONTROL_OFS, 32'h0);
        // retries on, one-bit back-off: sixteen attempts then retry error
        wreg(MAC_CONTROL_OFS, 32'h0000_00c0);
        xmit(2'h1, 8'h70);
        wreg(ADDR_HIGH_OFS, 32'h0200);
        wreg(ADDR_LOW_OFS, 32'h1122_3344);
        header(48'h0200_1122_3344, 1'b0);
        `CHK("unicast accept", 1'b1, acc)
        @(posedge clk) bv <= 1'b1;
        @(posedge clk) bv <= 1'b0;
        for (int i = 0; i < 10 && !rxv; i++) begin @(posedge clk); #1; end
        `CHK("rx valid", 1'b1, rxv)
        `CHK("rx word", 9'h15a, word)
        `CHK("rx in ready", 1'b1, inrdy)
        finish_test;
    end
endmodule // tb_top
